// *** logic/output_enable_mode_limit_control.sv ***
//Function
//- Shutdown pulse of minimum width stops output
//- Shutdown latches fault, red indicator
//- Fault clears only by power cycle
//- Trigger active level disables output, indicator off
//- Trigger inactive level enables output, indicator on
//- Reset power-up strap high inverts trigger sense unless top switch set
//- Standby: minimum low pulse disables output
//- Standby: high has no effect; on command
//- On/off commands when trigger disabled; on command also in standby
//- Save command stores output control mode
//- Switches zero: mode from analog pin
//- Nonzero location restores saved mode
//- Top switch set: lowest switch picks mode
//- Mode command: voltage, current or pin
//- Zero or 100xx: analog protection limits
//- Nonzero location restores saved limits
//- 101xx: negative maxima, positive minimum
//- 110xx positive maxima; 111xx both maxima
//- Fixed source follows digital limit registers
//- External source follows analog limit inputs
//- Lesser source picks smaller magnitude limit
//- Reference command selects analog or digital
`timescale 1ns/1ps
`default_nettype none
module output_enable_mode_limit_control #(
   parameter logic [11:0] RATED_MAX_CODE = 12'hFFF,  // 1.01 x rated limit code
   parameter logic [11:0] MIN_BOX_CODE   = 12'h199   // Minimum box limit code
)(
   // Clock and reset
   input  wire logic                         sys_clk_i,
   input  wire logic                         nrst_i,
   // APB slave
   input  wire logic                         psel_i,
   input  wire logic                         penable_i,
   input  wire logic                         pwrite_i,
   input  wire logic [7:0]                   paddr_i,
   input  wire logic [31:0]                  pwdata_i,
   output logic      [31:0]                  prdata_o,
   output logic                              pready_o,
   output logic                              pslverr_o,
   // External pins
   input  wire logic                         shutdown_i,
   input  wire logic                         trigger_i,
   input  wire logic                         analog_mode_i,
   input  wire logic [4:0]                   powerup_switch_bank_i,
   input  wire logic                         reset_powerup_i,
   // Digitised analog limit inputs, same clock
   input  wire logic [11:0]                  alim_vpos_i,
   input  wire logic [11:0]                  alim_vneg_i,
   input  wire logic [11:0]                  alim_cpos_i,
   input  wire logic [11:0]                  alim_cneg_i,
   // Settings store, same clock
   input  wire logic [1:0]                   stored_outctl_i,
   input  wire logic [1:0]                   stored_mode_i,
   input  wire logic [1:0]                   stored_vsrc_i,
   input  wire logic [1:0]                   stored_csrc_i,
   input  wire logic [23:0]                  stored_vlim_i,
   input  wire logic [23:0]                  stored_clim_i,
   output logic      [3:0]                   store_loc_o,
   output logic      [1:0]                   saved_outctl_o,
   output logic                              save_strobe_o,
   // Control outputs
   output logic                              output_enable_o,
   output logic                              output_led_o,
   output logic                              fault_indicator_o,
   output logic                              voltage_mode_o,
   output logic                              main_ref_ext_o,
   output logic      [11:0]                  vprot_pos_o,
   output logic      [11:0]                  vprot_neg_o,
   output logic      [11:0]                  cprot_pos_o,
   output logic      [11:0]                  cprot_neg_o
);
   import outctl_pkg::*;

   // Refuse a pulse width that the width counters cannot reach
   if (MIN_PULSE_CYC >= (1 << CNT_W))
   begin
      $error("Pulse counter too narrow");
   end

   // Whole state of the block
   typedef struct packed {
      logic [1:0]       sd_sync;     // Shutdown synchroniser
      logic [1:0]       tr_sync;     // Trigger synchroniser
      logic [1:0]       am_sync;     // Analog mode pin synchroniser
      logic [1:0]       rp_sync;     // Reset power-up strap synchroniser
      logic [9:0]       sw_sync;     // Switch bank synchroniser
      logic [1:0]       cfg_cnt;     // Settling count before capture
      logic             cfg_done;    // Power-up configuration taken
      logic             trig_inv;    // Trigger polarity inverted
      logic [CNT_W-1:0] sd_cnt;      // Shutdown width counter
      logic [CNT_W-1:0] tr_cnt;      // Trigger width counter
      logic             tr_low;      // Filtered trigger level is low
      logic             fault;       // Latched shutdown fault
      logic             out_en;      // Output on state
      logic [1:0]       outctl;      // Output control mode
      logic [1:0]       saved_oc;    // Saved output control mode
      logic             save_stb;    // Save pulse
      logic [1:0]       mmode;       // Main mode selection
      logic [1:0]       vsrc;        // Voltage protect source
      logic [1:0]       csrc;        // Current protect source
      logic             ref_ext;     // Main channel from analog reference
      logic [23:0]      vlim;        // Digital voltage protect limits
      logic [23:0]      clim;        // Digital current protect limits
      logic             vmode;       // Resolved voltage mode
      logic [11:0]      vp;          // Applied limits
      logic [11:0]      vn;
      logic [11:0]      cp;
      logic [11:0]      cn;
      logic [3:0]       loc;         // Store location
      logic [31:0]      rdata;       // APB read data
      logic             ready;       // APB ready
      logic             err;         // APB error
   } state_t;

   state_t s;       // Registered state
   state_t next_s;  // Next state

   // Smaller of two limit magnitudes
   function automatic logic [11:0] lesser(input logic [11:0] a, input logic [11:0] b);
      lesser = (a < b) ? a : b;
   endfunction

   // Limit by source selection
   function automatic logic [11:0] pick(input logic [1:0] src, input logic [11:0] dig,
                                        input logic [11:0] ana);
      unique case (src)
         PS_EXT:  pick = ana;
         PS_LESS: pick = lesser(dig, ana);
         default: pick = dig;
      endcase
   endfunction

   // Next state logic
   always_comb
   begin
      logic        acc;
      logic        wr;
      logic        trig_off;
      logic        low_done;
      logic [4:0]  sw;
      acc      = 1'b0;
      wr       = 1'b0;
      trig_off = 1'b0;
      low_done = 1'b0;
      sw       = 5'h00;
      next_s   = s;

      // Two-flop synchronisers
      next_s.sd_sync = {s.sd_sync[0], shutdown_i};
      next_s.tr_sync = {s.tr_sync[0], trigger_i};
      next_s.am_sync = {s.am_sync[0], analog_mode_i};
      next_s.rp_sync = {s.rp_sync[0], reset_powerup_i};
      next_s.sw_sync = {s.sw_sync[4:0], powerup_switch_bank_i};
      sw             = s.sw_sync[9:5];
      next_s.save_stb = 1'b0;

      // Shutdown width measurement, latch stays until power cycle
      if (s.sd_sync[1])
      begin
         if (s.sd_cnt < CNT_W'(MIN_PULSE_CYC))
            next_s.sd_cnt = s.sd_cnt + CNT_W'(1);
      end
      else
         next_s.sd_cnt = '0;
      if (s.sd_sync[1] && s.sd_cnt >= CNT_W'(MIN_PULSE_CYC - 1))
         next_s.fault = 1'b1;

      // Trigger level filter: level must stand the minimum width
      if (s.tr_sync[1] != s.tr_low)
         next_s.tr_cnt = '0;
      else if (s.tr_cnt < CNT_W'(MIN_PULSE_CYC))
         next_s.tr_cnt = s.tr_cnt + CNT_W'(1);
      if ((s.tr_sync[1] == s.tr_low) && s.tr_cnt >= CNT_W'(MIN_PULSE_CYC - 1))
      begin
         next_s.tr_low = ~s.tr_sync[1];
         next_s.tr_cnt = '0;
         low_done      = ~s.tr_sync[1];
      end
      trig_off = s.tr_low ^ s.trig_inv;

      // Power-up configuration capture after the switches settle
      if (!s.cfg_done)
      begin
         next_s.loc = sw[3:0];  // Store points at the location before capture reads it
         if (s.cfg_cnt != CFG_WAIT)
            next_s.cfg_cnt = s.cfg_cnt + 2'h1;
         else
         begin
            next_s.cfg_done = 1'b1;
            next_s.outctl   = stored_outctl_i;
            next_s.trig_inv = s.rp_sync[1] & ~sw[4];
            next_s.loc      = sw[3:0];
            if (sw == SW_ANALOG)
            begin
               next_s.mmode   = MM_EXT;
               next_s.vsrc    = PS_EXT;
               next_s.csrc    = PS_EXT;
               next_s.ref_ext = 1'b1;
            end
            else if (!sw[4])
            begin
               next_s.mmode = stored_mode_i;
               next_s.vsrc  = stored_vsrc_i;
               next_s.csrc  = stored_csrc_i;
               next_s.vlim  = stored_vlim_i;
               next_s.clim  = stored_clim_i;
            end
            else
            begin
               next_s.mmode   = sw[0] ? MM_VOLT : MM_CURR;
               next_s.ref_ext = sw[1];
               if (sw[4:2] == SW_TOP_EXT)
               begin
                  next_s.vsrc = PS_EXT;
                  next_s.csrc = PS_EXT;
               end
               else
               begin
                  next_s.vsrc = PS_FIXED;
                  next_s.csrc = PS_FIXED;
                  if (sw[4:2] == SW_TOP_NEG)
                  begin
                     next_s.vlim = {RATED_MAX_CODE, MIN_BOX_CODE};
                     next_s.clim = {RATED_MAX_CODE, MIN_BOX_CODE};
                  end
                  else if (sw[4:2] == SW_TOP_POS)
                  begin
                     next_s.vlim = {MIN_BOX_CODE, RATED_MAX_CODE};
                     next_s.clim = {MIN_BOX_CODE, RATED_MAX_CODE};
                  end
                  else
                  begin
                     next_s.vlim = {RATED_MAX_CODE, RATED_MAX_CODE};
                     next_s.clim = {RATED_MAX_CODE, RATED_MAX_CODE};
                  end
               end
            end
         end
      end

      // APB: one wait state, write takes effect on the ready edge
      acc = psel_i & penable_i;
      wr  = acc & s.ready & pwrite_i;
      next_s.ready = acc & ~s.ready;
      if (acc && !s.ready)
      begin
         next_s.err   = 1'b0;
         next_s.rdata = 32'h0000_0000;
         unique case (paddr_i)
            OFS_CTRL:   next_s.rdata[1:0] = s.outctl;
            OFS_CMD:    next_s.rdata = 32'h0000_0000;
            OFS_MODE:   next_s.rdata[6:0] = {s.ref_ext, s.csrc, s.vsrc, s.mmode};
            OFS_VLIM:   next_s.rdata = {4'h0, s.vlim[23:12], 4'h0, s.vlim[11:0]};
            OFS_CLIM:   next_s.rdata = {4'h0, s.clim[23:12], 4'h0, s.clim[11:0]};
            OFS_STATUS: next_s.rdata[9:0] = {sw, s.cfg_done, trig_off, s.vmode,
                                              s.fault, s.out_en & ~s.fault};
            default:    next_s.err = 1'b1;
         endcase
      end
      else
         next_s.err = 1'b0;  // Error stands only with ready

      // Register writes and commands
      if (wr && s.cfg_done)
      begin
         unique case (paddr_i)
            OFS_CTRL:
               if (pwdata_i[1:0] != 2'h3)
                  next_s.outctl = pwdata_i[1:0];
            OFS_CMD:
            begin
               if (pwdata_i[CMD_SAVE_BIT])
               begin
                  next_s.saved_oc = s.outctl;
                  next_s.save_stb = 1'b1;
               end
            end
            OFS_MODE:
            begin
               if (pwdata_i[1:0] != 2'h3)
                  next_s.mmode = pwdata_i[1:0];
               if (pwdata_i[MODE_VSRC_LSB +: 2] != 2'h3)
                  next_s.vsrc = pwdata_i[MODE_VSRC_LSB +: 2];
               if (pwdata_i[MODE_CSRC_LSB +: 2] != 2'h3)
                  next_s.csrc = pwdata_i[MODE_CSRC_LSB +: 2];
               next_s.ref_ext = pwdata_i[MODE_REF_BIT];
            end
            OFS_VLIM: next_s.vlim = {pwdata_i[LIM_NEG_LSB +: 12], pwdata_i[11:0]};
            OFS_CLIM: next_s.clim = {pwdata_i[LIM_NEG_LSB +: 12], pwdata_i[11:0]};
            default:  next_s.err = 1'b0;
         endcase
      end

      // Output on/off by control mode
      unique case (s.outctl)
         OC_TRIG_LEVEL:
            next_s.out_en = ~trig_off;
         OC_STANDBY:
         begin
            if (low_done)
               next_s.out_en = 1'b0;
            else if (wr && paddr_i == OFS_CMD && pwdata_i[CMD_ON_BIT])
               next_s.out_en = 1'b1;
         end
         default:
         begin
            if (wr && paddr_i == OFS_CMD && pwdata_i[CMD_OFF_BIT])
               next_s.out_en = 1'b0;
            else if (wr && paddr_i == OFS_CMD && pwdata_i[CMD_ON_BIT])
               next_s.out_en = 1'b1;
         end
      endcase
      // Fault keeps the output flop itself off
      if (!s.cfg_done || next_s.fault)
         next_s.out_en = 1'b0;

      // Resolved main mode
      unique case (s.mmode)
         MM_VOLT: next_s.vmode = 1'b1;
         MM_CURR: next_s.vmode = 1'b0;
         default: next_s.vmode = s.am_sync[1];
      endcase

      // Applied protection limits by source
      next_s.vp = pick(s.vsrc, s.vlim[11:0],  alim_vpos_i);
      next_s.vn = pick(s.vsrc, s.vlim[23:12], alim_vneg_i);
      next_s.cp = pick(s.csrc, s.clim[11:0],  alim_cpos_i);
      next_s.cn = pick(s.csrc, s.clim[23:12], alim_cneg_i);
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s       <= '0;
         s.vlim  <= {LIM_RESET, LIM_RESET};
         s.clim  <= {LIM_RESET, LIM_RESET};
         s.vmode <= 1'b1;
      end
      else
         s <= next_s;
   end

   // Outputs straight from the state register
   assign prdata_o          = s.rdata;
   assign pready_o          = s.ready;
   assign pslverr_o         = s.err;
   assign store_loc_o       = s.loc;
   assign saved_outctl_o    = s.saved_oc;
   assign save_strobe_o     = s.save_stb;
   assign fault_indicator_o = s.fault;
   assign output_enable_o   = s.out_en;
   assign output_led_o      = s.out_en;
   assign voltage_mode_o    = s.vmode;
   assign main_ref_ext_o    = s.ref_ext;
   assign vprot_pos_o       = s.vp;
   assign vprot_neg_o       = s.vn;
   assign cprot_pos_o       = s.cp;
   assign cprot_neg_o       = s.cn;
endmodule
`default_nettype wire

// *** include/outctl_pkg.sv ***
package outctl_pkg;
   // Clock and timing
   localparam int unsigned CLK_HZ          = 40000000;
   localparam int unsigned MIN_PULSE_US    = 100;
   localparam int unsigned MIN_PULSE_CYC   = (MIN_PULSE_US * (CLK_HZ / 1000000) < 1) ? 1 :
                                             MIN_PULSE_US * (CLK_HZ / 1000000);
   localparam int unsigned MAX_OFF_DELAY_MS = 200;
   localparam int unsigned MAX_OFF_CYC     = MAX_OFF_DELAY_MS * (CLK_HZ / 1000);
   localparam int unsigned CNT_W           = 12;
   localparam logic [1:0]  CFG_WAIT        = 2'h3;
   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_CMD         = 8'h04;
   localparam logic [7:0]  OFS_MODE        = 8'h08;
   localparam logic [7:0]  OFS_VLIM        = 8'h0C;
   localparam logic [7:0]  OFS_CLIM        = 8'h10;
   localparam logic [7:0]  OFS_STATUS      = 8'h14;
   // Field positions
   localparam int unsigned CMD_ON_BIT      = 0;
   localparam int unsigned CMD_OFF_BIT     = 1;
   localparam int unsigned CMD_SAVE_BIT    = 2;
   localparam int unsigned MODE_VSRC_LSB   = 2;
   localparam int unsigned MODE_CSRC_LSB   = 4;
   localparam int unsigned MODE_REF_BIT    = 6;
   localparam int unsigned LIM_NEG_LSB     = 16;
   // Output control modes
   localparam logic [1:0]  OC_TRIG_LEVEL   = 2'h0;
   localparam logic [1:0]  OC_STANDBY      = 2'h1;
   localparam logic [1:0]  OC_CMD_ONLY     = 2'h2;
   // Main mode selections
   localparam logic [1:0]  MM_VOLT         = 2'h0;
   localparam logic [1:0]  MM_CURR         = 2'h1;
   localparam logic [1:0]  MM_EXT          = 2'h2;
   // Protection limit sources
   localparam logic [1:0]  PS_FIXED        = 2'h0;
   localparam logic [1:0]  PS_EXT          = 2'h1;
   localparam logic [1:0]  PS_LESS         = 2'h2;
   // Power-up switch patterns
   localparam logic [4:0]  SW_ANALOG       = 5'h00;
   localparam logic [2:0]  SW_TOP_EXT      = 3'h4;
   localparam logic [2:0]  SW_TOP_NEG      = 3'h5;
   localparam logic [2:0]  SW_TOP_POS      = 3'h6;
   // Reset values
   localparam logic [11:0] LIM_RESET       = 12'hFFF;
endpackage

// *** test/outctl_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module outctl_checker
   import outctl_pkg::*;
(
   // Clock, reset and bus
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Pins and controls
   input wire logic shutdown_i,
   input wire logic output_enable_o,
   input wire logic output_led_o,
   input wire logic fault_indicator_o,
   input wire logic save_strobe_o
);
   logic [15:0] sd_run;  // Cycles the shutdown input has been high
   logic        sd_long; // A run has come within 4 cycles of the minimum width
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);
   // Saturating run counter, so a fault can be tied to a long enough pulse
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sd_run  <= 16'h0000;
         sd_long <= 1'b0;
      end
      else
      begin
         sd_run  <= !shutdown_i ? 16'h0000 : (&sd_run ? sd_run : sd_run + 16'h0001);
         sd_long <= sd_long | (sd_run >= 16'(MIN_PULSE_CYC - 4));
      end
   end
   fault_sticky_a: assert property (fault_indicator_o |=> fault_indicator_o)
      else $error("fault indicator released without reset");
   fault_blocks_a: assert property (fault_indicator_o |=> !output_enable_o && !output_led_o)
      else $error("output on while fault latched");
   led_tracks_a: assert property (output_led_o == output_enable_o)
      else $error("output indicator differs from output enable");
   shutdown_width_a: assert property ($rose(fault_indicator_o) |-> sd_long)
      else $error("fault raised by a short shutdown pulse");
   shutdown_bound_a: assert property (sd_run == 16'(MIN_PULSE_CYC + 8) |-> fault_indicator_o)
      else $error("long shutdown pulse did not latch a fault");
   ready_answer_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("no ready one cycle after access");
   ready_single_a: assert property (pready_o |=> !pready_o)
      else $error("ready held longer than one cycle");
   error_qual_a: assert property (pslverr_o |-> pready_o)
      else $error("slave error without ready");
   save_pulse_a: assert property (save_strobe_o |=> !save_strobe_o)
      else $error("save strobe longer than one cycle");
endmodule
bind output_enable_mode_limit_control outctl_checker i_chk (.sys_clk_i, .nrst_i, .psel_i,
   .penable_i, .pready_o, .pslverr_o, .shutdown_i, .output_enable_o, .output_led_o,
   .fault_indicator_o, .save_strobe_o);
`default_nettype wire

// *** test/outctl_store_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module outctl_store_model
   import outctl_pkg::*;
(
   // Clock
   input  wire logic        sys_clk_i,
   // Access from the block
   input  wire logic [3:0]  loc_i,
   input  wire logic [1:0]  save_mode_i,
   input  wire logic        save_i,
   // Contents at the selected location
   output logic      [1:0]  outctl_o,
   output logic      [1:0]  mode_o,
   output logic      [1:0]  vsrc_o,
   output logic      [1:0]  csrc_o,
   output logic      [23:0] vlim_o,
   output logic      [23:0] clim_o
);
   logic [1:0] saved_mode = OC_TRIG_LEVEL; // Nonvolatile, survives a power cycle
   // Take the output control mode on the save strobe
   always @(posedge sys_clk_i)
   begin
      if (save_i)
         saved_mode <= save_mode_i;
   end
   // Mode and limits at each location derive from its number; output control mode is shared
   assign outctl_o = saved_mode;
   assign mode_o   = loc_i[0] ? MM_CURR : MM_VOLT;
   assign vsrc_o   = PS_FIXED;
   assign csrc_o   = PS_FIXED;
   assign vlim_o   = {8'hA5, loc_i, 8'h5A, loc_i};
   assign clim_o   = {8'hC3, loc_i, 8'h3C, loc_i};
endmodule
`default_nettype wire

// *** test/output_enable_mode_limit_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module output_enable_mode_limit_control_bench;
   import outctl_pkg::*;
   localparam logic [11:0] RMAX = 12'hFFF; // Rated maximum code
   localparam logic [11:0] MBOX = 12'h199; // Minimum box code
   // Design inputs
   logic        sys_clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [7:0]  paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic        shutdown_i = 1'b0;
   logic        trigger_i = 1'b1;
   logic        analog_mode_i = 1'b1;
   logic [4:0]  powerup_switch_bank_i = 5'h03;
   logic        reset_powerup_i = 1'b0;
   logic [11:0] alim_vpos_i = 12'h300;
   logic [11:0] alim_vneg_i = 12'h050;
   logic [11:0] alim_cpos_i = 12'h300;
   logic [11:0] alim_cneg_i = 12'h050;
   logic [1:0]  stored_outctl_i, stored_mode_i, stored_vsrc_i, stored_csrc_i;
   logic [23:0] stored_vlim_i, stored_clim_i;
   // Design outputs
   logic [31:0] prdata_o;
   logic        pready_o, pslverr_o, save_strobe_o, output_enable_o, output_led_o;
   logic        fault_indicator_o, voltage_mode_o, main_ref_ext_o;
   logic [3:0]  store_loc_o;
   logic [1:0]  saved_outctl_o;
   logic [11:0] vprot_pos_o, vprot_neg_o, cprot_pos_o, cprot_neg_o;
   // Bench state and expectation tables
   int          error_cnt = 0;
   int          cmp_count = 0;
   logic [31:0] rd;
   logic        err;
   logic [11:0] ep [3] = '{12'h200, 12'h300, 12'h200};
   logic [11:0] en [3] = '{12'h100, 12'h050, 12'h050};
   logic [4:0]  sw [4] = '{5'h15, 5'h18, 5'h1C, 5'h11};
   logic [11:0] sp [4] = '{MBOX, RMAX, RMAX, 12'h300};
   logic [11:0] sn [4] = '{RMAX, MBOX, RMAX, 12'h050};
   logic        sv [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
   // 40 MHz clock
   always #12.5 sys_clk_i = ~sys_clk_i;
   output_enable_mode_limit_control #(.RATED_MAX_CODE(RMAX), .MIN_BOX_CODE(MBOX)) i_dut (
      .sys_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
      .pready_o, .pslverr_o, .shutdown_i, .trigger_i, .analog_mode_i, .powerup_switch_bank_i,
      .reset_powerup_i, .alim_vpos_i, .alim_vneg_i, .alim_cpos_i, .alim_cneg_i,
      .stored_outctl_i, .stored_mode_i, .stored_vsrc_i, .stored_csrc_i, .stored_vlim_i,
      .stored_clim_i, .store_loc_o, .saved_outctl_o, .save_strobe_o, .output_enable_o,
      .output_led_o, .fault_indicator_o, .voltage_mode_o, .main_ref_ext_o, .vprot_pos_o,
      .vprot_neg_o, .cprot_pos_o, .cprot_neg_o);
   outctl_store_model i_store (.sys_clk_i, .loc_i(store_loc_o), .save_mode_i(saved_outctl_o),
      .save_i(save_strobe_o), .outctl_o(stored_outctl_i), .mode_o(stored_mode_i),
      .vsrc_o(stored_vsrc_i), .csrc_o(stored_csrc_i), .vlim_o(stored_vlim_i),
      .clim_o(stored_clim_i));
   // Counts and verdict, the single end of the run
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      cmp_count++;
      if (got !== ex)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   // One APB transfer; holds the request until ready, then idles one cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 20);
      rd = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      if (n >= 20)
      begin
         error_cnt++;
         print_verdict();
      end
      @(posedge sys_clk_i);
   endtask
   // Bounded wait for the output enable level
   task automatic wait_oe(input logic v);
      int n;
      n = 0;
      while (output_enable_o !== v && n < 5000)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      if (n >= 5000)
      begin
         error_cnt++;
         print_verdict();
      end
   endtask
   // Power cycle with new switch and strap settings
   task automatic pwr(input logic [4:0] s, input logic r);
      nrst_i                <= 1'b0;
      powerup_switch_bank_i <= s;
      reset_powerup_i       <= r;
      cyc(4);
      nrst_i <= 1'b1;
      cyc(10);
   endtask
   initial
   begin
      cyc(2);
      nrst_i <= 1'b1;
      cyc(10);
      chk("store_loc", 32'h3, store_loc_o);
      chk("vmode", 32'h0, voltage_mode_o);
      chk("vprot_pos", 32'h5A3, vprot_pos_o);
      chk("cprot_neg", 32'hC33, cprot_neg_o);
      apb(1'b0, OFS_CMD, 32'h0);
      chk("cmd_read", 32'h0, rd);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped_err", 32'h1, err);
      wait_oe(1'b1);
      chk("oe_trig_high", 32'h1, output_led_o);
      trigger_i <= 1'b0;
      wait_oe(1'b0);
      chk("led_trig_low", 32'h0, output_led_o);
      apb(1'b1, OFS_CMD, 32'h1);
      cyc(5);
      chk("oe_cmd_ignored", 32'h0, output_enable_o);
      trigger_i <= 1'b1;
      wait_oe(1'b1);
      apb(1'b1, OFS_CTRL, 32'(OC_CMD_ONLY));
      trigger_i <= 1'b0;
      apb(1'b1, OFS_CMD, 32'h2);
      cyc(3);
      chk("oe_cmd_off", 32'h0, output_enable_o);
      apb(1'b1, OFS_CMD, 32'h1);
      cyc(4100);
      chk("oe_cmd_on", 32'h1, output_enable_o);
      apb(1'b1, OFS_CMD, 32'h3);
      cyc(3);
      chk("oe_on_and_off", 32'h0, output_enable_o);
      trigger_i <= 1'b1;
      apb(1'b1, OFS_CMD, 32'h1);
      cyc(4100);
      apb(1'b1, OFS_CTRL, 32'(OC_STANDBY));
      trigger_i <= 1'b0;
      cyc(4100);
      chk("oe_standby_pulse", 32'h0, output_enable_o);
      trigger_i <= 1'b1;
      cyc(4100);
      chk("oe_standby_high", 32'h0, output_enable_o);
      apb(1'b1, OFS_CMD, 32'h1);
      cyc(3);
      chk("oe_standby_on", 32'h1, output_enable_o);
      apb(1'b1, OFS_CMD, 32'h4);
      cyc(2);
      chk("saved_outctl", 32'(OC_STANDBY), saved_outctl_o);
      apb(1'b1, OFS_VLIM, 32'h0100_0200);
      apb(1'b1, OFS_CLIM, 32'h0100_0200);
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b1, OFS_MODE, {25'h0, i[0], i[1:0], i[1:0], i[1:0]});
         cyc(5);
         chk("vmode", 32'(i != 1), voltage_mode_o);
         chk("ref_ext", 32'(i[0]), main_ref_ext_o);
         chk("vprot_pos", 32'(ep[i]), vprot_pos_o);
         chk("vprot_neg", 32'(en[i]), vprot_neg_o);
         chk("cprot_pos", 32'(ep[i]), cprot_pos_o);
         chk("cprot_neg", 32'(en[i]), cprot_neg_o);
      end
      shutdown_i <= 1'b1;
      cyc(3000);
      shutdown_i <= 1'b0;
      cyc(10);
      chk("fault_short", 32'h0, fault_indicator_o);
      shutdown_i <= 1'b1;
      cyc(4100);
      shutdown_i <= 1'b0;
      cyc(5);
      chk("fault_long", 32'h1, fault_indicator_o);
      chk("oe_fault", 32'h0, output_enable_o);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("status_fault", 32'h1, 32'(rd[1]));
      apb(1'b1, OFS_CMD, 32'h1);
      cyc(5);
      chk("fault_held", 32'h1, fault_indicator_o);
      chk("oe_held_off", 32'h0, output_enable_o);
      analog_mode_i <= 1'b0;
      pwr(5'h00, 1'b1);
      chk("fault_cleared", 32'h0, fault_indicator_o);
      chk("vmode_pin", 32'h0, voltage_mode_o);
      chk("vprot_analog", 32'h300, vprot_pos_o);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl_restored", 32'(OC_STANDBY), rd);
      apb(1'b1, OFS_CTRL, 32'(OC_TRIG_LEVEL));
      cyc(4100);
      chk("oe_inv_high", 32'h0, output_enable_o);
      trigger_i <= 1'b0;
      wait_oe(1'b1);
      chk("oe_inv_low", 32'h1, output_led_o);
      analog_mode_i <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         pwr(sw[k], 1'b0);
         chk("vmode_sw", 32'(sv[k]), voltage_mode_o);
         chk("vprot_pos_sw", 32'(sp[k]), vprot_pos_o);
         chk("vprot_neg_sw", 32'(sn[k]), vprot_neg_o);
         chk("cprot_pos_sw", 32'(sp[k]), cprot_pos_o);
         chk("cprot_neg_sw", 32'(sn[k]), cprot_neg_o);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
